// file: verilog/sam_map.svh
// Register map, field positions, reset values and timing counts of the alarm manager
`ifndef SAM_MAP_SVH
`define SAM_MAP_SVH

// Number of alarm sources
`define SAM_NALM 40
// Register byte offsets
`define SAM_OFS_CTRL 8'h00
`define SAM_OFS_STATUS 8'h04
`define SAM_OFS_ALARM_LO 8'h08
`define SAM_OFS_ALARM_HI 8'h0c
`define SAM_OFS_DEV_LIMIT 8'h10
`define SAM_OFS_BUS_TO 8'h14
`define SAM_OFS_HB_TO 8'h18
// Control fields
`define SAM_CTRL_RST 0
`define SAM_CTRL_AUX 1
`define SAM_CTRL_MB_EN 2
`define SAM_CTRL_CAN_EN 3
// Status fields
`define SAM_ST_ACTIVE 0
`define SAM_ST_ENC_CLR 1
`define SAM_ST_DRIVE 2
`define SAM_ST_CODE_LSB 8
// Reset values
`define SAM_DEV_LIMIT_RST 32'h0000_ffff
`define SAM_BUS_TO_RST 16'h0064
`define SAM_HB_TO_RST 16'h0064
// Alarm indices of internally detected or special alarms
`define SAM_IDX_A05 4
`define SAM_IDX_A11 7
`define SAM_IDX_A12 8
`define SAM_IDX_A13 9
`define SAM_IDX_A15 11
`define SAM_IDX_A16 12
`define SAM_IDX_A25 18
`define SAM_IDX_A31 23
`define SAM_IDX_A60 36
`define SAM_IDX_A61 37
`define SAM_IDX_A90 39
// Alarms a reset never clears
`define SAM_NOCLEAR_MASK 40'h80_0080_0180
// Alarms that need the encoder cleared first
`define SAM_ENCGATE_MASK 40'h00_081c_0000
// Display codes, index 0 in the low byte
`define SAM_CODE_TABLE {8'h90, 8'h70, 8'h61, 8'h60, 8'h49, 8'h48, 8'h47, \
	8'h46, 8'h45, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40, 8'h34, 8'h33, 8'h31, \
	8'h30, 8'h28, 8'h27, 8'h26, 8'h25, 8'h23, 8'h22, 8'h19, 8'h18, 8'h17, \
	8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h06, 8'h05, 8'h04, \
	8'h03, 8'h02, 8'h01}
// Timing: clock period and millisecond
`define SAM_CLK_PERIOD_NS 25
`define SAM_MS_NS 1000000
`define SAM_MS_CYCLES (`SAM_MS_NS / `SAM_CLK_PERIOD_NS)
// Bus responses
`define SAM_RESP_OKAY 2'b00
`define SAM_RESP_SLVERR 2'b10

`endif

// file: verilog/sam_pkg.sv
// Types shared by the alarm manager modules
`include "sam_map.svh"
package sam_pkg;

	// Alarm vector
	typedef logic [`SAM_NALM-1:0] sam_alarm_t;

	// Watchdog state
	typedef struct packed {
		logic [15:0] cnt; // Elapsed milliseconds
		logic fired; // Timeout already reported
		logic expired; // One-cycle timeout pulse
	} sam_wd_t;

	// Top-level state
	typedef struct packed {
		sam_alarm_t alarm; // Latched alarms
		logic pin; // Fault pin level
		logic drive; // Motor drive enable
		logic [7:0] code; // Displayed code
		logic enc_clr; // Encoder alarm cleared by aux mode
		logic enc_req; // Aux clear pulse to encoder
		logic rst_prev; // Reset pin, previous sample
		logic [31:0] dev_limit; // Deviation limit
		logic [15:0] bus_to; // Bus timeout, ms
		logic [15:0] hb_to; // Heartbeat timeout, ms
		logic mb_en; // Bus watchdog enable
		logic can_en; // Heartbeat watchdog enable
		logic [31:0] tick_cnt; // Millisecond prescaler
		logic tick; // Millisecond pulse
		logic aw_got; // Write address held
		logic [7:0] awaddr; // Held write address
		logic w_got; // Write data held
		logic [31:0] wdata; // Held write data
		logic [3:0] wstrb; // Held strobes
		logic bvalid; // Write response pending
		logic [1:0] bresp; // Write response code
		logic rvalid; // Read data pending
		logic [31:0] rdata; // Read data
		logic [1:0] rresp; // Read response code
	} sam_top_t;

endpackage

// file: verilog/sam_sync2.sv
// Two-flop synchroniser for asynchronous input pins
module sam_sync2 #(
	parameter int W = 4 // Number of pins
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable
	input wire logic [W-1:0] din, // Raw pins
	output logic [W-1:0] dout // Synchronised pins
);
	import sam_pkg::*;

	// State: first and second stage
	typedef struct packed {
		logic [W-1:0] s1; // First stage, read only by s2
		logic [W-1:0] s2; // Second stage
	} sam_sync_t;

	sam_sync_t q; // Current state
	sam_sync_t d; // Next state

	////////////////////////////////////////////////////////////////////////
	// Shift pins through both stages
	always_comb begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
	end

	// Register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign dout = q.s2;
endmodule

// file: verilog/sam_watchdog.sv
// Millisecond receive watchdog: reports once when no kick arrives in time
module sam_watchdog (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable
	input wire logic enable, // Watchdog armed
	input wire logic tick, // One-millisecond pulse
	input wire logic kick, // Valid frame received
	input wire logic [15:0] limit, // Timeout in ms, zero disables
	output logic expired // One-cycle timeout pulse
);
	import sam_pkg::*;

	sam_wd_t q; // Current state
	sam_wd_t d; // Next state

	////////////////////////////////////////////////////////////////////////
	// Count milliseconds since the last kick
	always_comb begin
		d = q;
		d.expired = 1'b0;
		if (!enable || kick) begin
			// Rearm on every good frame
			d.cnt = 16'h0000;
			d.fired = 1'b0;
		end else if (tick && !q.fired && limit != 16'h0000) begin
			if (q.cnt + 16'h0001 >= limit) begin
				// Report once, then wait for a kick
				d.fired = 1'b1;
				d.expired = 1'b1;
			end else begin
				d.cnt = q.cnt + 16'h0001;
			end
		end
	end

	// Register the state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign expired = q.expired;
endmodule

// file: verilog/sam_top.sv
// Servo drive alarm manager: latches faults, shows codes, frees the motor
//
// Summary of operation
// - Any alarm removes drive; motor coasts, no brake
// - Fault pin high with alarm, else low
// - Single two-digit code; A01, A02 encoder lines
// - Overvoltage and undervoltage survive alarm reset
// - Regeneration overload survives alarm reset
// - A90 survives reset; all others but A11, A12, A31 reset-clearable
// - A25/26/27/41 clear only after aux encoder clear
// - A16 when deviation exceeds deviation limit
// - A15 on deviation counter overflow
// - A60 when bus frames stop for timeout
// - A61 when heartbeat misses its time
// - A05 when commutation inputs all equal
// - A17 for bad gear or fast pulses
// - A40 when encoder link fails
// - A44 to A47 for encoder frame errors
// - A48 when encoder extended field null
// - A49 when encoder stored sum fails
// - A13 clearable, on corrupt parameter storage
// - A42 absolute status, A43 counting error
// - A25 multi-turn error, A26 multi-turn overflow
// - Panel shows A plus two-digit number
`include "sam_map.svh"
module sam_top #(
	parameter int unsigned MS_CYCLES = `SAM_MS_CYCLES // Cycles per ms
) (
	input wire logic aclk, // Clock, 40 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic ce, // Clock enable, freezes all state
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire sam_pkg::sam_alarm_t fault_event, // Fault pulses, same clock
	input wire logic signed [31:0] position_deviation, // Deviation, pulses
	input wire logic deviation_overflow, // Deviation counter overflow
	input wire logic modbus_frame_ok, // Valid bus frame pulse
	input wire logic can_heartbeat, // Master heartbeat pulse
	input wire logic run_request, // Drive enable request
	input wire logic commutation_u_input, // Commutation U pin
	input wire logic commutation_v_input, // Commutation V pin
	input wire logic commutation_w_input, // Commutation W pin
	input wire logic alarm_reset_in, // Alarm reset pin, rising edge
	output logic fault_output_pin, // High while any alarm
	output logic motor_drive_en, // Power stage gate enable
	output logic [7:0] display_code, // Two BCD digits, 00 when normal
	output logic encoder_aux_clear // Pulse: clear encoder alarm state
);
	import sam_pkg::*;

	sam_top_t q; // Current state
	sam_top_t d; // Next state

	// Code table
	localparam logic [8*`SAM_NALM-1:0] CODE_TAB = `SAM_CODE_TABLE;

	logic [3:0] pins_s; // Synchronised pins
	logic mb_expired; // Bus watchdog timeout
	logic can_expired; // Heartbeat watchdog timeout
	logic uvw_bad; // Illegal commutation code
	logic [31:0] dev_mag; // Deviation magnitude
	logic dev_exceed; // Deviation above limit
	sam_alarm_t ev; // All alarm events this cycle
	logic aw_hs; // Write address taken
	logic w_hs; // Write data taken
	logic ar_hs; // Read address taken
	logic rst_pin_rise; // Reset pin rising edge
	logic rst_cmd; // Any alarm reset this cycle
	logic wr_rst; // Reset written by software

	////////////////////////////////////////////////////////////////////////
	// Highest-priority displayed code: lowest alarm index wins
	function automatic logic [7:0] alarm_code(input sam_alarm_t v);
		logic [7:0] c;
		c = 8'h00;
		for (int i = `SAM_NALM - 1; i >= 0; i--) begin
			if (v[i]) begin
				c = CODE_TAB[i*8 +: 8];
			end
		end
		return c;
	endfunction

	// Merge strobed bytes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	sam_sync2 #(.W(4)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.din({alarm_reset_in, commutation_w_input, commutation_v_input,
			commutation_u_input}),
		.dout(pins_s)
	);

	// Bus receive watchdog
	sam_watchdog u_wd_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.enable(q.mb_en),
		.tick(q.tick),
		.kick(modbus_frame_ok),
		.limit(q.bus_to),
		.expired(mb_expired)
	);

	// Master heartbeat watchdog
	sam_watchdog u_wd_hb (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.enable(q.can_en),
		.tick(q.tick),
		.kick(can_heartbeat),
		.limit(q.hb_to),
		.expired(can_expired)
	);

	////////////////////////////////////////////////////////////////////////
	// Fault detection
	assign uvw_bad = (&pins_s[2:0]) | ~(|pins_s[2:0]);
	assign dev_mag = position_deviation[31] ?
		32'(-position_deviation) : 32'(position_deviation);
	assign dev_exceed = dev_mag > q.dev_limit;

	// Gather events; external faults arrive by alarm index
	always_comb begin
		ev = fault_event;
		ev[`SAM_IDX_A05] = fault_event[`SAM_IDX_A05] | uvw_bad;
		ev[`SAM_IDX_A15] = fault_event[`SAM_IDX_A15] | deviation_overflow;
		ev[`SAM_IDX_A16] = fault_event[`SAM_IDX_A16] | dev_exceed;
		ev[`SAM_IDX_A60] = fault_event[`SAM_IDX_A60] | mb_expired;
		ev[`SAM_IDX_A61] = fault_event[`SAM_IDX_A61] | can_expired;
	end

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes; ready and valid only while clock is enabled,
	// so no handshake completes while the state is frozen
	assign s_axi_awready = ce & ~q.aw_got & ~q.bvalid;
	assign s_axi_wready = ce & ~q.w_got & ~q.bvalid;
	assign s_axi_arready = ce & ~q.rvalid;
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign rst_pin_rise = pins_s[3] & ~q.rst_prev;
	assign rst_cmd = wr_rst | rst_pin_rise;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic wr_aux;
		logic rst_now;
		logic [31:0] wd;
		logic [31:0] mw;
		sam_alarm_t clr;
		wr_aux = 1'b0;
		rst_now = 1'b0;
		wr_rst = 1'b0;
		wd = 32'h0000_0000;
		mw = 32'h0000_0000;
		clr = '0;
		d = q;
		// Millisecond prescaler
		if (q.tick_cnt >= MS_CYCLES - 1) begin
			d.tick_cnt = 32'h0000_0000;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 32'h0000_0001;
			d.tick = 1'b0;
		end
		d.rst_prev = pins_s[3];
		// Response channels retire
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		// Write address and data, either order
		if (aw_hs) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (d.aw_got && d.w_got) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `SAM_RESP_OKAY;
			wd = d.wdata;
			unique case (d.awaddr)
				`SAM_OFS_CTRL: begin
					// Command and enable bits live in byte 0
					if (d.wstrb[0]) begin
						wr_rst = wd[`SAM_CTRL_RST];
						wr_aux = wd[`SAM_CTRL_AUX];
						d.mb_en = wd[`SAM_CTRL_MB_EN];
						d.can_en = wd[`SAM_CTRL_CAN_EN];
					end
				end
				`SAM_OFS_DEV_LIMIT: begin
					d.dev_limit = merge(q.dev_limit, wd, d.wstrb);
				end
				`SAM_OFS_BUS_TO: begin
					mw = merge({16'h0000, q.bus_to}, wd, d.wstrb);
					d.bus_to = mw[15:0];
				end
				`SAM_OFS_HB_TO: begin
					mw = merge({16'h0000, q.hb_to}, wd, d.wstrb);
					d.hb_to = mw[15:0];
				end
				`SAM_OFS_STATUS, `SAM_OFS_ALARM_LO, `SAM_OFS_ALARM_HI: begin
					// Read-only, write ignored
				end
				default: begin
					d.bresp = `SAM_RESP_SLVERR;
				end
			endcase
		end
		// Alarm reset: clearable alarms only; local copy avoids a comb loop
		rst_now = wr_rst | rst_pin_rise;
		if (rst_now) begin
			clr = ~sam_alarm_t'(`SAM_NOCLEAR_MASK);
			if (!q.enc_clr) begin
				clr = clr & ~sam_alarm_t'(`SAM_ENCGATE_MASK);
			end
		end
		// Latch: a new event wins over a clear
		d.alarm = (q.alarm & ~clr) | ev;
		// Aux clear arms the gated alarms; used up by a reset
		d.enc_clr = wr_aux | (q.enc_clr & ~rst_now);
		d.enc_req = wr_aux;
		d.pin = |d.alarm;
		d.drive = run_request & ~(|d.alarm);
		d.code = alarm_code(d.alarm);
		// Read channel
		if (ar_hs) begin
			d.rvalid = 1'b1;
			d.rresp = `SAM_RESP_OKAY;
			d.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				`SAM_OFS_CTRL: begin
					d.rdata[`SAM_CTRL_MB_EN] = q.mb_en;
					d.rdata[`SAM_CTRL_CAN_EN] = q.can_en;
				end
				`SAM_OFS_STATUS: begin
					d.rdata[`SAM_ST_ACTIVE] = q.pin;
					d.rdata[`SAM_ST_ENC_CLR] = q.enc_clr;
					d.rdata[`SAM_ST_DRIVE] = q.drive;
					d.rdata[`SAM_ST_CODE_LSB +: 8] = q.code;
				end
				`SAM_OFS_ALARM_LO: begin
					d.rdata = q.alarm[31:0];
				end
				`SAM_OFS_ALARM_HI: begin
					d.rdata[`SAM_NALM-33:0] = q.alarm[`SAM_NALM-1:32];
				end
				`SAM_OFS_DEV_LIMIT: begin
					d.rdata = q.dev_limit;
				end
				`SAM_OFS_BUS_TO: begin
					d.rdata[15:0] = q.bus_to;
				end
				`SAM_OFS_HB_TO: begin
					d.rdata[15:0] = q.hb_to;
				end
				default: begin
					d.rresp = `SAM_RESP_SLVERR;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register, frozen while clock enable is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.dev_limit <= `SAM_DEV_LIMIT_RST;
			q.bus_to <= `SAM_BUS_TO_RST;
			q.hb_to <= `SAM_HB_TO_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// Outputs
	assign fault_output_pin = q.pin;
	assign motor_drive_en = q.drive;
	assign display_code = q.code;
	assign encoder_aux_clear = q.enc_req;
	assign s_axi_bvalid = q.bvalid & ce;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid & ce;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Reset request and a quiet parameter alarm
	sequence s_reset_req;
		ce && rst_cmd;
	endsequence
	sequence s_a13_quiet;
		q.alarm[`SAM_IDX_A13] && !ev[`SAM_IDX_A13];
	endsequence

	AST_NO_DRIVE: assert property (fault_output_pin |-> !motor_drive_en)
		else $error("motor driven during alarm");
	AST_PIN_LEVEL: assert property (fault_output_pin ==
		(display_code != 8'h00)) else $error("fault pin and display disagree");
	AST_A01_CODE: assert property (q.alarm[0] |-> display_code == 8'h01)
		else $error("A01 not shown");
	AST_UV_KEEP: assert property (s_reset_req ##0 q.alarm[`SAM_IDX_A12] |=>
		q.alarm[`SAM_IDX_A12]) else $error("undervoltage cleared by reset");
	AST_REGEN_KEEP: assert property (s_reset_req ##0 q.alarm[`SAM_IDX_A31]
		|=> q.alarm[`SAM_IDX_A31]) else $error("regen alarm cleared");
	AST_A90_KEEP: assert property (s_reset_req ##0 q.alarm[`SAM_IDX_A90] |=>
		q.alarm[`SAM_IDX_A90]) else $error("mismatch alarm cleared");
	AST_ENC_GATE: assert property (s_reset_req ##0 !q.enc_clr ##0
		q.alarm[`SAM_IDX_A25] |=> q.alarm[`SAM_IDX_A25])
		else $error("gated alarm cleared without aux clear");
	AST_DEV_RAISE: assert property (ce && dev_exceed |=>
		q.alarm[`SAM_IDX_A16] ##1 fault_output_pin)
		else $error("deviation alarm missing");
	AST_UVW_RAISE: assert property (ce && uvw_bad |=> q.alarm[`SAM_IDX_A05])
		else $error("commutation alarm missing");
	AST_BUS_TO: assert property (ce && mb_expired |=>
		q.alarm[`SAM_IDX_A60] && display_code != 8'h00)
		else $error("bus timeout alarm missing");
	AST_RESET_CLR: assert property (s_reset_req and s_a13_quiet |=>
		!q.alarm[`SAM_IDX_A13]) else $error("parameter alarm not cleared");
	AST_LATCH: assert property (ce && !rst_cmd |=>
		(q.alarm & $past(q.alarm)) == $past(q.alarm))
		else $error("alarm lost without reset");
	AST_CODE_SHOWN: assert property (display_code == alarm_code(q.alarm))
		else $error("displayed code wrong");
endmodule

// file: tb/sam_host_model.sv
// Host controller model: watches the fault pin, requests run, pulses reset
module sam_host_model (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic fault_output_pin, // Fault pin from the drive
	input wire logic clr_req, // Bench asks for a reset pulse
	output logic run_request, // Drive enable request
	output logic alarm_reset_in // Alarm reset pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold = 0; // Cycles left on the reset pin
	initial begin
		run_request = 1'b0;
		alarm_reset_in = 1'b0;
	end
	// Run only while healthy; reset pin held 4 cycles, long enough to sync
	always @(posedge aclk) begin
		run_request <= aresetn && !fault_output_pin;
		if (clr_req) hold = 4;
		alarm_reset_in <= (hold > 0);
		if (hold > 0) hold = hold - 1;
	end
endmodule

// file: tb/servo_alarm_manager_tb_top.sv
// Self-checking bench of the alarm manager against a bit-vector model
`include "sam_map.svh"
module servo_alarm_manager_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sam_pkg::*;
	localparam logic [319:0] CODES = `SAM_CODE_TABLE; // Code per index
	localparam logic [39:0] NC = 40'h80_0080_0180; // A11 A12 A31 A90
	localparam logic [39:0] GATE = 40'h00_081c_0000; // A25 A26 A27 A41
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	sam_alarm_t fault_event = '0; // Fault pulses
	logic signed [31:0] pos_dev = 32'sh0;
	logic dev_ovf = 1'b0, mb_ok = 1'b0, hb_ok = 1'b0, clr_req = 1'b0;
	logic u_in = 1'b1, v_in = 1'b0, w_in = 1'b0; // Legal commutation
	logic run_req, rst_pin, fault_pin, drive_en, aux_clr;
	logic [7:0] disp;
	int n_fail = 0, num_checks = 0, aux_cnt = 0;
	logic [39:0] m_alm = 40'h0; // Model: latched alarms
	bit m_enc = 1'b0; // Model: encoder cleared by aux mode

	always #12.5 aclk = ~aclk;
	// Count aux clear pulses
	always @(posedge aclk) if (aux_clr === 1'b1) aux_cnt++;

	sam_top #(.MS_CYCLES(8)) u_dut (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .fault_event(fault_event),
		.position_deviation(pos_dev), .deviation_overflow(dev_ovf),
		.modbus_frame_ok(mb_ok), .can_heartbeat(hb_ok),
		.run_request(run_req), .commutation_u_input(u_in),
		.commutation_v_input(v_in), .commutation_w_input(w_in),
		.alarm_reset_in(rst_pin), .fault_output_pin(fault_pin),
		.motor_drive_en(drive_en), .display_code(disp),
		.encoder_aux_clear(aux_clr));
	sam_host_model u_host (.aclk(aclk), .aresetn(aresetn),
		.fault_output_pin(fault_pin), .clr_req(clr_req),
		.run_request(run_req), .alarm_reset_in(rst_pin));

	////////////////////////////////////////////////////////////////////////
	// Verdict and closing
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Compare any value
	task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Expected display code: lowest alarm index wins
	function automatic logic [7:0] exp_code(input logic [39:0] a);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 39; i >= 0; i--) if (a[i]) c = CODES[i*8+:8];
		return c;
	endfunction
	// Settle, then compare pin, drive and display with the model
	task automatic chk_out;
		repeat (4) @(negedge aclk);
		chk_val({fault_pin, drive_en, disp},
			{|m_alm, run_req && !m_alm, exp_code(m_alm)});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Bus master: sample at negedge, change right after posedge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit ha, hw, hb;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
		end while (!hb);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit ha, hr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
		end while (!hr);
	endtask
	// Alarm registers against the model
	task automatic chk_regs;
		logic [31:0] lo, hi, st;
		logic [1:0] r;
		axi_rd(`SAM_OFS_ALARM_LO, lo, r);
		axi_rd(`SAM_OFS_ALARM_HI, hi, r);
		chk_val({hi[7:0], lo}, m_alm);
		axi_rd(`SAM_OFS_STATUS, st, r);
		chk_val(st, {exp_code(m_alm), 5'h0, run_req && !m_alm, m_enc,
			|m_alm});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Hardware reset; synced pins start equal, so clear A05 afterwards
	task automatic do_reset;
		logic [1:0] r;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (5) @(posedge aclk);
		axi_wr(`SAM_OFS_CTRL, 32'h1, r);
		m_alm = 40'h0;
		m_enc = 1'b0;
	endtask
	// One-cycle fault pulse on index k
	task automatic ev(input int k);
		@(posedge aclk);
		fault_event[k] <= 1'b1;
		@(posedge aclk);
		fault_event[k] <= 1'b0;
		m_alm[k] = 1'b1;
	endtask
	// Alarm reset by pin (host) or by register
	task automatic clr(input bit pin);
		logic [1:0] r;
		if (pin) begin
			@(posedge aclk);
			clr_req <= 1'b1;
			@(posedge aclk);
			clr_req <= 1'b0;
			repeat (12) @(posedge aclk);
		end else
			axi_wr(`SAM_OFS_CTRL, 32'h1, r);
		m_alm = m_alm & (NC | (m_enc ? 40'h0 : GATE));
		m_enc = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Bounded run time
	initial begin
		repeat (40000) @(posedge aclk);
		n_fail++;
		end_of_test;
	end
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int s, k, lim, c;
		s = $urandom(38781);
		do_reset;
		axi_rd(`SAM_OFS_DEV_LIMIT, d, r);
		chk_val(d, `SAM_DEV_LIMIT_RST);
		axi_rd(`SAM_OFS_BUS_TO, d, r);
		chk_val(d, 32'h64);
		axi_rd(8'h1c, d, r);
		chk_val({r, d}, {`SAM_RESP_SLVERR, 32'h0});
		axi_wr(8'h1c, 32'h0, r);
		chk_val(r, `SAM_RESP_SLVERR);
		chk_out;
		$display("test registers done");
		// Every alarm index, from a random start
		s = $urandom % 40;
		for (int i = 0; i < 40; i++) begin
			k = (i + s) % 40;
			ev(k);
			chk_out;
			chk_regs;
			clr(i[0]);
			chk_out;
			if (m_alm & GATE) begin
				c = aux_cnt;
				axi_wr(`SAM_OFS_CTRL, 32'h2, r);
				m_enc = 1'b1;
				repeat (2) @(posedge aclk);
				chk_val(aux_cnt - c, 40'h1);
				clr(1'b0);
				chk_out;
			end
			if (m_alm) begin
				do_reset;
				chk_out;
			end
		end
		$display("test alarm table done");
		// Deviation limit, equal then exceeded, then counter overflow
		lim = $urandom_range(5000, 100);
		axi_wr(`SAM_OFS_DEV_LIMIT, lim, r);
		@(posedge aclk) pos_dev <= lim;
		chk_out;
		@(posedge aclk) pos_dev <= -(lim + 1);
		m_alm[`SAM_IDX_A16] = 1'b1;
		chk_out;
		@(posedge aclk) pos_dev <= 0;
		dev_ovf <= 1'b1;
		@(posedge aclk) dev_ovf <= 1'b0;
		m_alm[`SAM_IDX_A15] = 1'b1;
		chk_out;
		chk_regs;
		clr(1'b0);
		chk_out;
		$display("test deviation done");
		// Commutation pins all low, then all high
		for (int p = 0; p < 2; p++) begin
			@(posedge aclk) {u_in, v_in, w_in} <= p ? 3'h7 : 3'h0;
			m_alm[`SAM_IDX_A05] = 1'b1;
			chk_out;
			@(posedge aclk) {u_in, v_in, w_in} <= 3'h4;
			repeat (4) @(posedge aclk);
			clr(1'b1);
			chk_out;
		end
		$display("test commutation done");
		// Bus and heartbeat watchdogs: kicked, then starved
		for (int j = 0; j < 2; j++) begin
			axi_wr(j ? `SAM_OFS_HB_TO : `SAM_OFS_BUS_TO, 32'h3, r);
			axi_wr(`SAM_OFS_CTRL, j ? 32'h8 : 32'h4, r);
			axi_rd(`SAM_OFS_CTRL, d, r);
			chk_val(d, j ? 32'h8 : 32'h4);
			repeat (8) begin
				@(posedge aclk);
				if (j) hb_ok <= 1'b1;
				else mb_ok <= 1'b1;
				@(posedge aclk);
				hb_ok <= 1'b0;
				mb_ok <= 1'b0;
				repeat (6) @(posedge aclk);
			end
			chk_out;
			repeat (60) @(posedge aclk);
			m_alm[j ? `SAM_IDX_A61 : `SAM_IDX_A60] = 1'b1;
			chk_out;
			clr(1'b0);
			chk_out;
		end
		$display("test watchdogs done");
		// Clock enable low: state frozen, a fault pulse is lost
		@(posedge aclk) ce <= 1'b0;
		ev(3);
		m_alm[3] = 1'b0;
		@(posedge aclk) ce <= 1'b1;
		chk_out;
		$display("test clock enable done");
		end_of_test;
	end
endmodule
